// ==== logic/dshb_device.sv ====
// Message module end: handshake words, buffer memory, channel control
`timescale 1ns/1ps
module dshb_device
    import dshb_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Backplane side
    dshb_if.device          bus,
    // Serial engine side, channel 0 and 1
    input  wire logic [1:0] rx_byte_valid,
    input  wire logic [7:0] rx_byte0,
    input  wire logic [7:0] rx_byte1,
    input  wire logic [1:0] rx_err,
    output logic      [1:0] tx_byte_valid,
    output logic      [7:0] tx_byte0,
    output logic      [7:0] tx_byte1,
    input  wire logic [1:0] tx_byte_ready,
    input  wire logic [1:0] tx_err,
    // Modem lines from pins
    input  wire logic [1:0] cts_pin,
    input  wire logic [1:0] dsr_pin,
    output logic      [1:0] dsr_seen
);
    logic [15:0] mem [0:MEM_WORDS-1];
    logic [1:0]  cts_s1_r, cts_s2_r, dsr_s1_r, dsr_s2_r;
    logic [15:0] cmd0_r, cmd1_r, cmd_prev0_r, cmd_prev1_r;
    logic [1:0]  wr_ready_r, tx_done_r, tx_err_r, tx_busy_r;
    logic [1:0]  rd_ready_r, rx_done_r, rx_err_r;
    logic [9:0]  rx_cnt0_r, rx_cnt1_r, tx_cnt0_r, tx_cnt1_r;
    logic [7:0]  tx_data0_r, tx_data1_r;
    logic [1:0]  tx_valid_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic [15:0] stat0_w, stat1_w;
    logic [1:0]  tx_start_w, rd_start_w, cts_ok_w, tx_take_w;
    logic        host_wr_w, host_rd_w, rx_wr0_w, rx_wr1_w;

    function automatic logic [15:0] pack_status(input logic w, input logic d,
                                                input logic e, input logic r,
                                                input logic c, input logic x);
        pack_status = RESET_WORD;
        pack_status[BIT_WR_READY] = w;
        pack_status[BIT_TX_DONE] = d;
        pack_status[BIT_TX_ERR] = e;
        pack_status[BIT_RD_READY] = r;
        pack_status[BIT_RX_DONE] = c;
        pack_status[BIT_RX_ERR] = x;
    endfunction

    // Unused bits fall out as zero from the packing
    assign stat0_w = pack_status(wr_ready_r[0], tx_done_r[0], tx_err_r[0],
                      rd_ready_r[0], rx_done_r[0], rx_err_r[0]);
    assign stat1_w = pack_status(wr_ready_r[1], tx_done_r[1], tx_err_r[1],
                      rd_ready_r[1], rx_done_r[1], rx_err_r[1]);
    assign bus.input_word0 = stat0_w;
    assign bus.input_word1 = stat1_w;
    assign bus.blk_rdata  = rdata_r;
    assign bus.blk_rvalid = rvalid_r;

    // Rising edges of command bits; unused command bits are masked off
    assign tx_start_w[0] = cmd0_r[BIT_TX_START] & ~cmd_prev0_r[BIT_TX_START];
    assign tx_start_w[1] = cmd1_r[BIT_TX_START] & ~cmd_prev1_r[BIT_TX_START];
    assign rd_start_w[0] = cmd0_r[BIT_RD_START] & ~cmd_prev0_r[BIT_RD_START];
    assign rd_start_w[1] = cmd1_r[BIT_RD_START] & ~cmd_prev1_r[BIT_RD_START];
    assign cts_ok_w = cts_s2_r;
    assign dsr_seen = {dsr_s2_r[1], 1'b0};

    assign host_wr_w = bus.blk_req & bus.blk_wr
                       & (bus.blk_addr >= ADDR_PARAM);
    assign host_rd_w = bus.blk_req & ~bus.blk_wr;
    // Received bytes land one per word in the channel receive area
    assign rx_wr0_w = rx_byte_valid[0] & ~rd_ready_r[0]
                      & (rx_cnt0_r < AREA_WORDS[9:0]);
    assign rx_wr1_w = rx_byte_valid[1] & ~rd_ready_r[1]
                      & (rx_cnt1_r < AREA_WORDS[9:0]);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cts_s1_r <= 2'h0;
            cts_s2_r <= 2'h0;
            dsr_s1_r <= 2'h0;
            dsr_s2_r <= 2'h0;
        end else begin
            cts_s1_r <= cts_pin;
            cts_s2_r <= cts_s1_r;
            dsr_s1_r <= dsr_pin;
            dsr_s2_r <= dsr_s1_r;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd0_r      <= RESET_WORD;
            cmd1_r      <= RESET_WORD;
            cmd_prev0_r <= RESET_WORD;
            cmd_prev1_r <= RESET_WORD;
        end else begin
            cmd0_r      <= bus.output_word0 & CMD_MASK;
            cmd1_r      <= bus.output_word1 & CMD_MASK;
            cmd_prev0_r <= cmd0_r;
            cmd_prev1_r <= cmd1_r;
        end
    end

    // Memory: host write port, receive write port, mirror of words 0-3
    always_ff @(posedge core_clk) begin
        if (host_wr_w) begin
            mem[bus.blk_addr] <= bus.blk_wdata;
        end
        if (rx_wr0_w) begin
            mem[ADDR_CH1_RX + {1'b0, rx_cnt0_r}] <= {8'h00, rx_byte0};
        end
        if (rx_wr1_w) begin
            mem[ADDR_CH2_RX + {1'b0, rx_cnt1_r}] <= {8'h00, rx_byte1};
        end
    end

    // Read port; the mirror words are served from live logic
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= RESET_WORD;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= host_rd_w;
            if (host_rd_w) begin
                unique case (bus.blk_addr)
                    ADDR_CH1_STATUS: rdata_r <= stat0_w;
                    ADDR_CH2_STATUS: rdata_r <= stat1_w;
                    ADDR_CH1_CMD:    rdata_r <= cmd0_r;
                    ADDR_CH2_CMD:    rdata_r <= cmd1_r;
                    default:         rdata_r <= mem[bus.blk_addr];
                endcase
            end
        end
    end

    // Per-channel handshake flags; events win over clears
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ready_r <= 2'h3;
            tx_busy_r  <= 2'h0;
            tx_done_r  <= 2'h0;
            tx_err_r   <= 2'h0;
            rd_ready_r <= 2'h0;
            rx_done_r  <= 2'h0;
            rx_err_r   <= 2'h0;
            rx_cnt0_r  <= 10'h000;
            rx_cnt1_r  <= 10'h000;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (tx_start_w[c] && wr_ready_r[c]) begin
                    wr_ready_r[c] <= 1'b0;
                    tx_busy_r[c]  <= 1'b1;
                    tx_done_r[c]  <= 1'b0;
                    tx_err_r[c]   <= 1'b0;
                end else if (tx_busy_r[c] && tx_err[c]) begin
                    tx_busy_r[c]  <= 1'b0;
                    tx_err_r[c]   <= 1'b1;
                    wr_ready_r[c] <= 1'b1;
                end
                if (rd_start_w[c] && rd_ready_r[c]) begin
                    rd_ready_r[c] <= 1'b0;
                    rx_done_r[c]  <= 1'b0;
                    rx_err_r[c]   <= 1'b0;
                end
                if (rx_err[c]) begin
                    rx_err_r[c] <= 1'b1;
                end
            end
            if (tx_busy_r[0] && tx_take_w[0]
                && tx_data0_r == TRAIL_DEFAULT) begin
                tx_busy_r[0] <= 1'b0;
                tx_done_r[0] <= 1'b1;
                wr_ready_r[0] <= 1'b1;
            end
            if (tx_busy_r[1] && tx_take_w[1]
                && tx_data1_r == TRAIL_DEFAULT) begin
                tx_busy_r[1] <= 1'b0;
                tx_done_r[1] <= 1'b1;
                wr_ready_r[1] <= 1'b1;
            end
            if (rd_start_w[0] && rd_ready_r[0]) begin
                rx_cnt0_r <= 10'h000;
            end else if (rx_wr0_w) begin
                rx_cnt0_r <= rx_cnt0_r + 10'h001;
                if (rx_byte0 == TRAIL_DEFAULT) begin
                    rx_done_r[0]  <= 1'b1;
                    rd_ready_r[0] <= 1'b1;
                end
            end
            if (rd_start_w[1] && rd_ready_r[1]) begin
                rx_cnt1_r <= 10'h000;
            end else if (rx_wr1_w) begin
                rx_cnt1_r <= rx_cnt1_r + 10'h001;
                if (rx_byte1 == TRAIL_DEFAULT) begin
                    rx_done_r[1]  <= 1'b1;
                    rd_ready_r[1] <= 1'b1;
                end
            end
        end
    end

    // Transmit fetch: one byte per word from the transmit area.
    // The memory read is shared, so a fetch waits for a free read cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_r <= 2'h0;
            tx_data0_r <= 8'h00;
            tx_data1_r <= 8'h00;
            tx_cnt0_r  <= 10'h000;
            tx_cnt1_r  <= 10'h000;
        end else begin
            if (tx_start_w[0] && wr_ready_r[0]) begin
                tx_cnt0_r <= 10'h000;
            end else if (tx_busy_r[0] && !tx_valid_r[0] && cts_ok_w[0]
                         && !host_rd_w) begin
                tx_data0_r    <= mem[ADDR_CH1_TX + {1'b0, tx_cnt0_r}][7:0];
                tx_valid_r[0] <= 1'b1;
                tx_cnt0_r     <= tx_cnt0_r + 10'h001;
            end else if (tx_take_w[0]
                         || (tx_valid_r[0] && !tx_busy_r[0])) begin
                tx_valid_r[0] <= 1'b0;
            end
            if (tx_start_w[1] && wr_ready_r[1]) begin
                tx_cnt1_r <= 10'h000;
            end else if (tx_busy_r[1] && !tx_valid_r[1] && cts_ok_w[1]
                         && !host_rd_w) begin
                tx_data1_r    <= mem[ADDR_CH2_TX + {1'b0, tx_cnt1_r}][7:0];
                tx_valid_r[1] <= 1'b1;
                tx_cnt1_r     <= tx_cnt1_r + 10'h001;
            end else if (tx_take_w[1]
                         || (tx_valid_r[1] && !tx_busy_r[1])) begin
                tx_valid_r[1] <= 1'b0;
            end
        end
    end

    // Bytes are offered only while clear-to-send holds
    assign tx_byte_valid = tx_valid_r & cts_ok_w;
    assign tx_byte0 = tx_data0_r;
    assign tx_byte1 = tx_data1_r;
    // A byte counts as taken only while offered, so a ready seen while
    // clear-to-send is low cannot swallow a byte
    assign tx_take_w = tx_byte_valid & tx_byte_ready;

endmodule // dshb_device

// ==== logic/dshb_pkg.sv ====
// Shared constants and types for the dual serial host buffer port
package dshb_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int MEM_WORDS = 2048;
    localparam int MAX_BLOCK = 256;
    localparam int CNT_W = 9;
    // Buffer map
    localparam logic [10:0] ADDR_CH1_STATUS = 11'h000;
    localparam logic [10:0] ADDR_CH2_STATUS = 11'h001;
    localparam logic [10:0] ADDR_CH1_CMD = 11'h002;
    localparam logic [10:0] ADDR_CH2_CMD = 11'h003;
    localparam logic [10:0] ADDR_PARAM = 11'h004;
    localparam logic [10:0] ADDR_CH1_RX = 11'h080;
    localparam logic [10:0] ADDR_CH1_TX = 11'h240;
    localparam logic [10:0] ADDR_CH2_RX = 11'h400;
    localparam logic [10:0] ADDR_CH2_TX = 11'h5C0;
    localparam logic [10:0] ADDR_INHIBIT = 11'h780;
    localparam logic [10:0] AREA_WORDS = 11'h1C0;
    // Handshake word bit positions
    localparam int BIT_WR_READY = 15;
    localparam int BIT_TX_DONE = 14;
    localparam int BIT_TX_ERR = 13;
    localparam int BIT_RD_READY = 7;
    localparam int BIT_RX_DONE = 6;
    localparam int BIT_RX_ERR = 5;
    localparam int BIT_TX_START = 15;
    localparam int BIT_RD_START = 7;
    localparam logic [15:0] STATUS_MASK = 16'hE0E0;
    localparam logic [15:0] CMD_MASK = 16'h8080;
    localparam logic [7:0] TRAIL_DEFAULT = 8'h0D;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Host-side register offsets (own map)
    localparam logic [3:0] REG_CMD0 = 4'h0;
    localparam logic [3:0] REG_CMD1 = 4'h1;
    localparam logic [3:0] REG_STAT0 = 4'h2;
    localparam logic [3:0] REG_STAT1 = 4'h3;
    localparam logic [3:0] REG_BLK_ADDR = 4'h4;
    localparam logic [3:0] REG_BLK_CNT = 4'h5;
    localparam logic [3:0] REG_BLK_CTRL = 4'h6;
    localparam logic [3:0] REG_BLK_DATA = 4'h7;
    localparam logic [3:0] REG_BLK_STAT = 4'h8;
    localparam logic [3:0] REG_BLK_PTR = 4'h9;
    typedef enum logic [1:0] {
        DSHB_OP_NONE,
        DSHB_OP_READ,
        DSHB_OP_WRITE
    } dshb_op_type;
endpackage

// ==== logic/dshb_if.sv ====
// Backplane link between host controller and message module
`timescale 1ns/1ps
interface dshb_if;
    import dshb_pkg::*;
    // Direct handshake words
    logic [15:0] input_word0;
    logic [15:0] input_word1;
    logic [15:0] output_word0;
    logic [15:0] output_word1;
    // Block transfer channel
    logic        blk_req;
    logic        blk_wr;
    logic [10:0] blk_addr;
    logic [15:0] blk_wdata;
    logic [15:0] blk_rdata;
    logic        blk_rvalid;
    modport device (
        output input_word0, input_word1, blk_rdata, blk_rvalid,
        input  output_word0, output_word1, blk_req, blk_wr, blk_addr,
               blk_wdata
    );
    modport host (
        input  input_word0, input_word1, blk_rdata, blk_rvalid,
        output output_word0, output_word1, blk_req, blk_wr, blk_addr,
               blk_wdata
    );
endinterface // dshb_if

// ==== logic/dshb_host.sv ====
// Controller end: handshake words and block transfers from a register port
`timescale 1ns/1ps
module dshb_host
    import dshb_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Software register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Backplane side
    dshb_if.host             bus
);
    logic [15:0] cmd0_r, cmd1_r, stat0_r, stat1_r, rdata_r;
    logic [10:0] addr_r, ptr_r;
    logic [8:0]  cnt_r, left_r;
    logic [15:0] wbuf_r, rbuf_r;
    logic        wpend_r, rbuf_vld_r, blk_err_r;
    dshb_op_type op_r;
    logic        wr_cmd0_w, wr_cmd1_w, wr_data_w, wr_ctrl_w, issue_w;
    logic        range_ok_w;

    assign wr_cmd0_w = reg_wr & (reg_addr == REG_CMD0);
    assign wr_cmd1_w = reg_wr & (reg_addr == REG_CMD1);
    assign wr_data_w = reg_wr & (reg_addr == REG_BLK_DATA);
    assign wr_ctrl_w = reg_wr & (reg_addr == REG_BLK_CTRL);
    // Count 1..256, and never into the inhibited region
    assign range_ok_w = (cnt_r != 9'h000) && (cnt_r <= 9'h100)
        && ({1'b0, addr_r} + {3'h0, cnt_r} <= {1'b0, ADDR_INHIBIT});
    // Read: one word outstanding at a time until done, paused while the word waits
    assign issue_w = (op_r == DSHB_OP_READ) & (left_r != 9'h000)
                     & ~rbuf_vld_r & ~bus.blk_rvalid
                     | (op_r == DSHB_OP_WRITE) & wpend_r;
    assign bus.blk_req   = issue_w;
    assign bus.blk_wr    = (op_r == DSHB_OP_WRITE);
    assign bus.blk_addr  = ptr_r;
    assign bus.blk_wdata = wbuf_r;
    // Handshake words driven straight, bypassing any batch refresh
    assign bus.output_word0 = cmd0_r & CMD_MASK;
    assign bus.output_word1 = cmd1_r & CMD_MASK;
    assign reg_rdata = rdata_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd0_r  <= RESET_WORD;
            cmd1_r  <= RESET_WORD;
            stat0_r <= RESET_WORD;
            stat1_r <= RESET_WORD;
        end else begin
            stat0_r <= bus.input_word0 & STATUS_MASK;
            stat1_r <= bus.input_word1 & STATUS_MASK;
            if (wr_cmd0_w) begin
                cmd0_r <= reg_wdata & CMD_MASK;
            end
            if (wr_cmd1_w) begin
                cmd1_r <= reg_wdata & CMD_MASK;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r     <= 11'h000;
            cnt_r      <= 9'h000;
            ptr_r      <= 11'h000;
            left_r     <= 9'h000;
            op_r       <= DSHB_OP_NONE;
            wpend_r    <= 1'b0;
            wbuf_r     <= RESET_WORD;
            rbuf_r     <= RESET_WORD;
            rbuf_vld_r <= 1'b0;
            blk_err_r  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == REG_BLK_ADDR) begin
                addr_r <= reg_wdata[10:0];
            end
            if (reg_wr && reg_addr == REG_BLK_CNT) begin
                cnt_r <= reg_wdata[8:0];
            end
            if (wr_ctrl_w) begin
                if (range_ok_w && reg_wdata[1:0] != 2'h0) begin
                    op_r      <= reg_wdata[0] ? DSHB_OP_READ : DSHB_OP_WRITE;
                    ptr_r     <= addr_r;
                    left_r    <= cnt_r;
                    blk_err_r <= 1'b0;
                end else begin
                    op_r      <= DSHB_OP_NONE;
                    left_r    <= 9'h000;
                    blk_err_r <= 1'b1;
                end
            end else if (issue_w) begin
                ptr_r  <= ptr_r + 11'h001;
                left_r <= left_r - 9'h001;
                if (op_r == DSHB_OP_WRITE) begin
                    wpend_r <= 1'b0;
                    if (left_r == 9'h001) begin
                        op_r <= DSHB_OP_NONE;
                    end
                end
            end else if (op_r == DSHB_OP_READ && left_r == 9'h000
                         && !rbuf_vld_r && !bus.blk_rvalid) begin
                op_r <= DSHB_OP_NONE;
            end
            if (wr_data_w && op_r == DSHB_OP_WRITE) begin
                wbuf_r  <= reg_wdata;
                wpend_r <= 1'b1;
            end
            if (bus.blk_rvalid) begin
                rbuf_r     <= bus.blk_rdata;
                rbuf_vld_r <= 1'b1;
            end else if (reg_rd && reg_addr == REG_BLK_DATA) begin
                rbuf_vld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= RESET_WORD;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CMD0:     rdata_r <= cmd0_r;
                REG_CMD1:     rdata_r <= cmd1_r;
                REG_STAT0:    rdata_r <= stat0_r;
                REG_STAT1:    rdata_r <= stat1_r;
                REG_BLK_ADDR: rdata_r <= {5'h00, addr_r};
                REG_BLK_CNT:  rdata_r <= {7'h00, cnt_r};
                REG_BLK_DATA: rdata_r <= rbuf_r;
                REG_BLK_STAT: rdata_r <= {12'h000, blk_err_r, wpend_r,
                                          rbuf_vld_r, op_r != DSHB_OP_NONE};
                REG_BLK_PTR:  rdata_r <= {5'h00, ptr_r};
                default:      rdata_r <= RESET_WORD;
            endcase
        end else begin
            rdata_r <= RESET_WORD;
        end
    end

endmodule // dshb_host

// ==== sim/dshb_link_props.sv ====
// Checker on the backplane link between host and module ends
`timescale 1ns/1ps
module dshb_link_props
    import dshb_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Handshake words
    input wire logic [15:0] input_word0,
    input wire logic [15:0] input_word1,
    input wire logic [15:0] output_word0,
    input wire logic [15:0] output_word1,
    // Block channel
    input wire logic        blk_req,
    input wire logic        blk_wr,
    input wire logic [10:0] blk_addr,
    input wire logic [15:0] blk_wdata,
    input wire logic [15:0] blk_rdata,
    input wire logic        blk_rvalid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire rd_req = blk_req && !blk_wr;
    sequence s_tx_go;
        $rose(output_word0[15]) && input_word0[15];
    endsequence
    sequence s_rd_go;
        $rose(output_word0[7]) && input_word0[7];
    endsequence
    a_stat_unused_zero: assert property (
        ((input_word0 | input_word1) & ~STATUS_MASK) == 16'h0000)
        else $error("unused status bit set");
    a_cmd_unused_zero: assert property (
        ((output_word0 | output_word1) & ~CMD_MASK) == 16'h0000)
        else $error("unused command bit set");
    a_read_answered: assert property (rd_req |=> blk_rvalid)
        else $error("block read not answered");
    a_answer_has_cause: assert property (
        blk_rvalid |-> $past(rd_req))
        else $error("read answer without request");
    a_addr_allowed: assert property (
        blk_req |-> blk_addr < ADDR_INHIBIT)
        else $error("inhibited address reached");
    a_status_mirror: assert property (
        rd_req && blk_addr == ADDR_CH1_STATUS
        |=> blk_rdata == $past(input_word0)) else $error("status mirror");
    a_command_mirror: assert property (
        rd_req && blk_addr == ADDR_CH2_CMD
        |=> blk_rdata == $past(output_word1)) else $error("command mirror");
    a_tx_start_clears: assert property (
        s_tx_go |-> ##[1:3] input_word0[14:13] == 2'b00)
        else $error("transmit flags kept");
    a_rd_start_clears: assert property (
        s_rd_go |-> ##[1:3] input_word0[6] == 1'b0)
        else $error("receive flag kept");
endmodule // dshb_link_props

// ==== sim/dual_serial_host_buffer_port_test.sv ====
// Bench joining host end and module end over the backplane link
`timescale 1ns/1ps
module dual_serial_host_buffer_port_test;
    import dshb_pkg::*;
    logic        core_clk, rst_n, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [1:0]  rx_v, rx_e, tx_v, tx_rdy, tx_e, cts, dsr, dsr_seen;
    logic [7:0]  rx_b0, rx_b1, tx_b0, tx_b1;
    int          fail_count, checked;
    dshb_if link ();
    dshb_host i_dshb_host (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(link));
    dshb_device i_dshb_device (.core_clk(core_clk), .rst_n(rst_n),
        .bus(link), .rx_byte_valid(rx_v), .rx_byte0(rx_b0),
        .rx_byte1(rx_b1), .rx_err(rx_e), .tx_byte_valid(tx_v),
        .tx_byte0(tx_b0), .tx_byte1(tx_b1), .tx_byte_ready(tx_rdy),
        .tx_err(tx_e), .cts_pin(cts), .dsr_pin(dsr), .dsr_seen(dsr_seen));
    dshb_link_props i_dshb_link_props (.core_clk(core_clk), .rst_n(rst_n),
        .input_word0(link.input_word0), .input_word1(link.input_word1),
        .output_word0(link.output_word0), .output_word1(link.output_word1),
        .blk_req(link.blk_req), .blk_wr(link.blk_wr),
        .blk_addr(link.blk_addr), .blk_wdata(link.blk_wdata),
        .blk_rdata(link.blk_rdata), .blk_rvalid(link.blk_rvalid));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(posedge core_clk);
    endtask
    // Read data stand one cycle only, so they are taken at its closing edge
    task automatic rd(logic [3:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask
    task automatic rdchk(logic [3:0] a, logic [15:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask
    // Status follows a command two cycles late plus the copy stage
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask
    task automatic blk_start(logic [10:0] a, logic [15:0] n, logic [15:0] c);
        wr(REG_BLK_ADDR, {5'h00, a});
        wr(REG_BLK_CNT, n);
        wr(REG_BLK_CTRL, c);
    endtask
    task automatic blk_get(logic [15:0] exp);
        d = 16'h0000;
        for (int i = 0; i < 20 && d[1] !== 1'b1; i++) rd(REG_BLK_STAT, d);
        if (d[1] !== 1'b1) begin
            fail_count++;
            test_done();
        end else begin
            rdchk(REG_BLK_DATA, exp);
        end
    endtask
    task automatic rx(int ch, logic [7:0] b, logic e);
        rx_b0 <= b;
        rx_b1 <= b;
        rx_v  <= e ? 2'b00 : 2'(1 << ch);
        rx_e  <= e ? 2'(1 << ch) : 2'b00;
        @(posedge core_clk);
        rx_v  <= 2'b00;
        rx_e  <= 2'b00;
        @(posedge core_clk);
    endtask
    task automatic tx_get(logic [7:0] exp);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            @(posedge core_clk);
            seen = (tx_v[1] === 1'b1);
        end
        if (!seen) begin
            fail_count++;
            test_done();
        end else begin
            chk({8'h00, tx_b1}, {8'h00, exp});
        end
    endtask
    task automatic t_map();
        rdchk(REG_STAT0, 16'h8000);
        rdchk(REG_STAT1, 16'h8000);
        rdchk(4'hF, 16'h0000);
        wr(REG_CMD1, 16'h7F7F);
        rdchk(REG_CMD1, 16'h0000);
        blk_start(ADDR_CH1_STATUS, 16'h0004, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            blk_get(i < 2 ? 16'h8000 : 16'h0000);
        end
    endtask
    task automatic t_rx();
        rx(0, 8'h41, 1'b0);
        rx(0, 8'h42, 1'b0);
        rx(0, TRAIL_DEFAULT, 1'b0);
        settle();
        rdchk(REG_STAT0, 16'h80C0);
        blk_start(ADDR_CH1_RX, 16'h0003, 16'h0001);
        blk_get(16'h0041);
        blk_get(16'h0042);
        blk_get(16'h000D);
        wr(REG_CMD0, 16'h0080);
        settle();
        rdchk(REG_STAT0, 16'h8000);
        wr(REG_CMD0, 16'h0000);
        rx(1, 8'h00, 1'b1);
        settle();
        rdchk(REG_STAT1, 16'h8020);
    endtask
    task automatic t_tx();
        blk_start(ADDR_CH2_TX, 16'h0002, 16'h0002);
        wr(REG_BLK_DATA, 16'h0048);
        wr(REG_BLK_DATA, 16'h000D);
        wr(REG_CMD1, 16'h8000);
        settle();
        chk({15'h0000, tx_v[1]}, 16'h0000);
        cts <= 2'b10;
        tx_get(8'h48);
        tx_get(8'h0D);
        settle();
        rd(REG_STAT1, d);
        chk(d & 16'hE000, 16'hC000);
        wr(REG_CMD0, 16'h8000);
        settle();
        tx_e <= 2'b01;
        @(posedge core_clk);
        tx_e <= 2'b00;
        settle();
        rd(REG_STAT0, d);
        chk(d & 16'hE000, 16'hA000);
        wr(REG_CMD0, 16'h0000);
        wr(REG_CMD0, 16'h8000);
        settle();
        rdchk(REG_STAT0, 16'h0000);
        dsr <= 2'b11;
        settle();
        chk({14'h0000, dsr_seen}, 16'h0002);
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {rx_v, rx_e, tx_e, cts, dsr, rx_b0, rx_b1} = '0;
        tx_rdy = 2'b11;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_map();
        t_rx();
        t_tx();
        test_done();
    end
endmodule // dual_serial_host_buffer_port_test
